// ==== verilog/dcst_params.svh ====
`ifndef DCST_PARAMS_SVH
`define DCST_PARAMS_SVH

// ****************************************************************
// register offsets, byte addresses inside the hub register window
// ****************************************************************
`define DCST_OFS_ACT       12'h652
`define DCST_OFS_WR        12'h656
`define DCST_OFS_RD        12'h658
`define DCST_OFS_STAT      12'h65c

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define DCST_RST_ACT       32'h00000000
`define DCST_RST_WR        16'h0000
`define DCST_RST_RD        24'h000000
`define DCST_MASK_ACT      32'h0fffffff
`define DCST_MASK_RD       24'h1fffff

// ****************************************************************
// activate timing fields
// ****************************************************************
`define DCST_ACT_WIN_HI    27
`define DCST_ACT_WIN_LO    22
`define DCST_ACT_CHKOFF    21
`define DCST_ACT_AA_HI     20
`define DCST_ACT_AA_LO     17
`define DCST_ACT_PA_HI     16
`define DCST_ACT_PA_LO     13
`define DCST_ACT_PALL_HI   12
`define DCST_ACT_PALL_LO   9
`define DCST_ACT_REF_HI    8
`define DCST_ACT_REF_LO    0

// ****************************************************************
// write timing fields
// ****************************************************************
`define DCST_WR_AW_HI      15
`define DCST_WR_AW_LO      12
`define DCST_WR_WWS_HI     11
`define DCST_WR_WWS_LO     8
`define DCST_WR_WWO_HI     7
`define DCST_WR_WWO_LO     4
`define DCST_WR_RW_HI      3
`define DCST_WR_RW_LO      0

// ****************************************************************
// read timing fields
// ****************************************************************
`define DCST_RD_AR_HI      20
`define DCST_RD_AR_LO      17
`define DCST_RD_WRS_HI     16
`define DCST_RD_WRS_LO     12
`define DCST_RD_WRO_HI     11
`define DCST_RD_WRO_LO     8
`define DCST_RD_RRS_HI     7
`define DCST_RD_RRS_LO     4
`define DCST_RD_RRO_HI     3
`define DCST_RD_RRO_LO     0

// ****************************************************************
// geometry and activate window limit
// ****************************************************************
`define DCST_NRANK         2
`define DCST_NBANK         8
`define DCST_ACT_LIMIT     3'h4

`endif

// ==== verilog/dcst_pkg.sv ====
package dcst_pkg;

  typedef enum logic [2:0] {
    DCST_CMD_ACT    = 3'h0,
    DCST_CMD_PRE    = 3'h1,
    DCST_CMD_PREALL = 3'h2,
    DCST_CMD_REF    = 3'h3,
    DCST_CMD_RD     = 3'h4,
    DCST_CMD_WR     = 3'h5
  } dcst_cmd_t;

  typedef logic [8:0] dcst_cnt_t;
  typedef logic [0:0] dcst_rank_t;
  typedef logic [2:0] dcst_bank_t;

  // a spacing counter loaded with N lets the next launch land N cycles later
  function automatic logic dcst_open(input dcst_cnt_t c);
    return c <= 9'h001;
  endfunction

  function automatic dcst_cnt_t dcst_tick(input dcst_cnt_t c);
    return (c == 9'h000) ? 9'h000 : c - 9'h001;
  endfunction

endpackage

// ==== verilog/dcst_act_window.sv ====
`include "dcst_params.svh"

module dcst_act_window (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // configuration
  input  wire logic [5:0] act_window_len,
  input  wire logic       act_limit_check_off,
  // activity
  input  wire logic       act_launch,
  output logic            act_blocked,
  output logic [2:0]      act_count
);
  import dcst_pkg::*;

  logic [5:0] timer_q;
  logic [2:0] count_q;

  // a launch at timer 1 or 0 begins a fresh window, the old one ends there
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      timer_q <= 6'h00;
    end else if (act_launch && timer_q <= 6'h01) begin
      timer_q <= act_window_len;
    end else if (timer_q != 6'h00) begin
      timer_q <= timer_q - 6'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count_q <= 3'h0;
    end else if (act_launch && timer_q <= 6'h01) begin
      count_q <= (act_window_len != 6'h00) ? 3'h1 : 3'h0;
    end else if (act_launch && count_q != 3'h7) begin
      count_q <= count_q + 3'h1;
    end else if (timer_q <= 6'h01) begin
      count_q <= 3'h0;
    end
  end

  // never lets a fifth activate into one window unless act_limit_check_off is set
  assign act_blocked = !act_limit_check_off && timer_q > 6'h01 &&
                       count_q >= `DCST_ACT_LIMIT;
  assign act_count   = count_q;

endmodule // dcst_act_window

// ==== verilog/dcst_tracker.sv ====
`include "dcst_params.svh"

module dcst_tracker (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // register port
  input  wire logic [11:0]         reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [31:0]         reg_wdata,
  output logic [31:0]              reg_rdata_q,
  // scheduler request
  input  wire logic                req_valid,
  input  wire dcst_pkg::dcst_cmd_t req_cmd,
  input  wire dcst_pkg::dcst_rank_t req_rank,
  input  wire dcst_pkg::dcst_bank_t req_bank,
  // command launched toward the ranks
  output logic                     issue_q,
  output dcst_pkg::dcst_cmd_t      issue_cmd_q,
  output dcst_pkg::dcst_rank_t     issue_rank_q,
  output dcst_pkg::dcst_bank_t     issue_bank_q
);
  import dcst_pkg::*;

  localparam int NR = `DCST_NRANK;
  localparam int NB = `DCST_NBANK;

  // ****************************************************************
  // timing registers
  // ****************************************************************
  logic [31:0] act_timing_q;
  logic [15:0] write_timing_q;
  logic [23:0] read_timing_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      act_timing_q <= `DCST_RST_ACT;
    end else if (reg_wr && reg_addr == `DCST_OFS_ACT) begin
      act_timing_q <= reg_wdata & `DCST_MASK_ACT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      write_timing_q <= `DCST_RST_WR;
    end else if (reg_wr && reg_addr == `DCST_OFS_WR) begin
      write_timing_q <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      read_timing_q <= `DCST_RST_RD;
    end else if (reg_wr && reg_addr == `DCST_OFS_RD) begin
      read_timing_q <= reg_wdata[23:0] & `DCST_MASK_RD;
    end
  end

  // ****************************************************************
  // field extraction
  // ****************************************************************
  logic [5:0] act_window_len;
  logic       act_limit_check_off;
  dcst_cnt_t  act_act_gap, pre_act_gap, preall_act_gap, refresh_act_gap;
  dcst_cnt_t  act_write_gap, write_write_same_rank_gap, write_write_other_rank_gap;
  dcst_cnt_t  read_write_gap, act_read_gap, write_read_same_rank_gap;
  dcst_cnt_t  write_read_other_rank_gap, read_read_same_rank_gap;
  dcst_cnt_t  read_read_other_rank_gap;

  assign act_window_len      = act_timing_q[`DCST_ACT_WIN_HI:`DCST_ACT_WIN_LO];
  assign act_limit_check_off = act_timing_q[`DCST_ACT_CHKOFF];
  assign act_act_gap     = {5'h00, act_timing_q[`DCST_ACT_AA_HI:`DCST_ACT_AA_LO]};
  assign pre_act_gap     = {5'h00, act_timing_q[`DCST_ACT_PA_HI:`DCST_ACT_PA_LO]};
  assign preall_act_gap  = {5'h00, act_timing_q[`DCST_ACT_PALL_HI:`DCST_ACT_PALL_LO]};
  assign refresh_act_gap = act_timing_q[`DCST_ACT_REF_HI:`DCST_ACT_REF_LO];
  assign act_write_gap   = {5'h00, write_timing_q[`DCST_WR_AW_HI:`DCST_WR_AW_LO]};
  assign write_write_same_rank_gap  =
    {5'h00, write_timing_q[`DCST_WR_WWS_HI:`DCST_WR_WWS_LO]};
  assign write_write_other_rank_gap =
    {5'h00, write_timing_q[`DCST_WR_WWO_HI:`DCST_WR_WWO_LO]};
  assign read_write_gap  = {5'h00, write_timing_q[`DCST_WR_RW_HI:`DCST_WR_RW_LO]};
  assign act_read_gap    = {5'h00, read_timing_q[`DCST_RD_AR_HI:`DCST_RD_AR_LO]};
  assign write_read_same_rank_gap  =
    {4'h0, read_timing_q[`DCST_RD_WRS_HI:`DCST_RD_WRS_LO]};
  assign write_read_other_rank_gap =
    {5'h00, read_timing_q[`DCST_RD_WRO_HI:`DCST_RD_WRO_LO]};
  assign read_read_same_rank_gap   =
    {5'h00, read_timing_q[`DCST_RD_RRS_HI:`DCST_RD_RRS_LO]};
  assign read_read_other_rank_gap  =
    {5'h00, read_timing_q[`DCST_RD_RRO_HI:`DCST_RD_RRO_LO]};

  // ****************************************************************
  // target decode, shared by every per-rank and per-bank spacing counter
  // ****************************************************************
  logic [NR-1:0]         rank_sel;
  logic [NR-1:0][NB-1:0] bank_sel;

  always_comb begin
    rank_sel = '0;
    bank_sel = '0;
    for (int r = 0; r < NR; r++) begin
      rank_sel[r] = (req_rank == dcst_rank_t'(r));
      for (int b = 0; b < NB; b++) begin
        bank_sel[r][b] = rank_sel[r] && (req_bank == dcst_bank_t'(b));
      end
    end
  end

  // ****************************************************************
  // activate window per rank
  // ****************************************************************
  logic [NR-1:0] win_blocked;
  logic [2:0]    win_count [NR];
  logic          issue_d;

  for (genvar r = 0; r < NR; r++) begin : g_win
    dcst_act_window u_win (
      .clk_sys             (clk_sys),
      .resetn              (resetn),
      .act_window_len      (act_window_len),
      .act_limit_check_off (act_limit_check_off),
      .act_launch          (issue_d && req_cmd == DCST_CMD_ACT &&
                            req_rank == dcst_rank_t'(r)),
      .act_blocked         (win_blocked[r]),
      .act_count           (win_count[r])
    );
  end

  // ****************************************************************
  // spacing counters, each reloaded by the command that starts its gap
  // ****************************************************************
  dcst_cnt_t aa_q     [NR];
  dcst_cnt_t ref_q    [NR];
  dcst_cnt_t ww_q     [NR];
  dcst_cnt_t wr2rd_q  [NR];
  dcst_cnt_t rr_q     [NR];
  dcst_cnt_t pa_q     [NR][NB];
  dcst_cnt_t aw_q     [NR][NB];
  dcst_cnt_t ar_q     [NR][NB];
  dcst_cnt_t preall_q;
  dcst_cnt_t rw_q;

  // a counter that several commands reload keeps the longer wait, so a short
  // cross-rank gap never cuts a running same-rank gap short
  function automatic dcst_cnt_t reload_max(input dcst_cnt_t cur, input dcst_cnt_t gap);
    dcst_cnt_t left;
    left = dcst_tick(cur);
    return (gap > left) ? gap : left;
  endfunction

  logic l_act, l_pre, l_preall, l_ref, l_rd, l_wr;
  assign l_act    = issue_d && req_cmd == DCST_CMD_ACT;
  assign l_pre    = issue_d && req_cmd == DCST_CMD_PRE;
  assign l_preall = issue_d && req_cmd == DCST_CMD_PREALL;
  assign l_ref    = issue_d && req_cmd == DCST_CMD_REF;
  assign l_rd     = issue_d && req_cmd == DCST_CMD_RD;
  assign l_wr     = issue_d && req_cmd == DCST_CMD_WR;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int r = 0; r < NR; r++) begin
        aa_q[r]    <= 9'h000;
        ref_q[r]   <= 9'h000;
        ww_q[r]    <= 9'h000;
        wr2rd_q[r] <= 9'h000;
        rr_q[r]    <= 9'h000;
      end
    end else begin
      for (int r = 0; r < NR; r++) begin
        aa_q[r]    <= (l_act && rank_sel[r]) ? act_act_gap : dcst_tick(aa_q[r]);
        ref_q[r]   <= (l_ref && rank_sel[r]) ? refresh_act_gap : dcst_tick(ref_q[r]);
        ww_q[r]    <= l_wr ? reload_max(ww_q[r], rank_sel[r] ?
                                        write_write_same_rank_gap :
                                        write_write_other_rank_gap)
                           : dcst_tick(ww_q[r]);
        wr2rd_q[r] <= l_wr ? reload_max(wr2rd_q[r], rank_sel[r] ?
                                        write_read_same_rank_gap :
                                        write_read_other_rank_gap)
                           : dcst_tick(wr2rd_q[r]);
        rr_q[r]    <= l_rd ? reload_max(rr_q[r], rank_sel[r] ?
                                        read_read_same_rank_gap :
                                        read_read_other_rank_gap)
                           : dcst_tick(rr_q[r]);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int r = 0; r < NR; r++) begin
        for (int b = 0; b < NB; b++) begin
          pa_q[r][b] <= 9'h000;
          aw_q[r][b] <= 9'h000;
          ar_q[r][b] <= 9'h000;
        end
      end
    end else begin
      for (int r = 0; r < NR; r++) begin
        for (int b = 0; b < NB; b++) begin
          pa_q[r][b] <= (l_pre && bank_sel[r][b]) ? pre_act_gap
                                                   : dcst_tick(pa_q[r][b]);
          aw_q[r][b] <= (l_act && bank_sel[r][b]) ? act_write_gap
                                                   : dcst_tick(aw_q[r][b]);
          ar_q[r][b] <= (l_act && bank_sel[r][b]) ? act_read_gap
                                                   : dcst_tick(ar_q[r][b]);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      preall_q <= 9'h000;
      rw_q     <= 9'h000;
    end else begin
      preall_q <= l_preall ? preall_act_gap : dcst_tick(preall_q);
      rw_q     <= l_rd ? read_write_gap : dcst_tick(rw_q);
    end
  end

  // ****************************************************************
  // launch decision
  // ****************************************************************
  logic ok;

  always_comb begin
    ok = 1'b0;
    unique case (req_cmd)
      DCST_CMD_ACT: ok = dcst_open(aa_q[req_rank]) &&
                         dcst_open(ref_q[req_rank]) &&
                         dcst_open(pa_q[req_rank][req_bank]) &&
                         dcst_open(preall_q) &&
                         !win_blocked[req_rank];
      DCST_CMD_WR:  ok = dcst_open(aw_q[req_rank][req_bank]) &&
                         dcst_open(ww_q[req_rank]) &&
                         dcst_open(rw_q);
      DCST_CMD_RD:  ok = dcst_open(ar_q[req_rank][req_bank]) &&
                         dcst_open(rr_q[req_rank]) &&
                         dcst_open(wr2rd_q[req_rank]);
      // precharge, precharge-all and refresh spacings live outside this block,
      // so those commands go out as soon as the launch slot is free
      DCST_CMD_PRE, DCST_CMD_PREALL, DCST_CMD_REF: ok = 1'b1;
      default:      ok = 1'b0;
    endcase
  end

  // one launch at most every other cycle, so a request held one cycle late
  // by the scheduler cannot launch twice
  assign issue_d = req_valid && !issue_q && ok;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      issue_q      <= 1'b0;
      issue_cmd_q  <= DCST_CMD_ACT;
      issue_rank_q <= '0;
      issue_bank_q <= '0;
    end else begin
      issue_q <= issue_d;
      if (issue_d) begin
        issue_cmd_q  <= req_cmd;
        issue_rank_q <= req_rank;
        issue_bank_q <= req_bank;
      end
    end
  end

  // ****************************************************************
  // read back
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DCST_OFS_ACT:  reg_rdata_q <= act_timing_q;
        `DCST_OFS_WR:   reg_rdata_q <= {16'h0000, write_timing_q};
        `DCST_OFS_RD:   reg_rdata_q <= {8'h00, read_timing_q};
        `DCST_OFS_STAT: reg_rdata_q <= {24'h000000, win_blocked,
                                        win_count[1], win_count[0]};
        default:        reg_rdata_q <= 32'h00000000;
      endcase
    end
  end

endmodule // dcst_tracker

// ==== verif/dcst_tracker_assertions.sv ====
`include "dcst_params.svh"

module dcst_tracker_chk
  import dcst_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  // scheduler request
  input  wire logic        req_valid,
  input  wire dcst_cmd_t   req_cmd,
  input  wire dcst_rank_t  req_rank,
  input  wire dcst_bank_t  req_bank,
  // launched command
  input  wire logic        issue_q,
  input  wire dcst_cmd_t   issue_cmd_q,
  input  wire dcst_rank_t  issue_rank_q,
  input  wire dcst_bank_t  issue_bank_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // shadow of timing registers and launch times
  // ****
  logic [15:0] wr_q;
  logic [23:0] rd_q;
  logic [31:0] cyc_q;
  logic [31:0] wr_t_q [2];
  logic [31:0] rd_t_q [2];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_q <= 16'h0000;
      rd_q <= 24'h000000;
    end else if (reg_wr && reg_addr == `DCST_OFS_WR) begin
      wr_q <= reg_wdata[15:0];
    end else if (reg_wr && reg_addr == `DCST_OFS_RD) begin
      rd_q <= reg_wdata[23:0];
    end
  end

  // counter starts high so the first command after reset sees no false gap
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cyc_q  <= 32'h00000400;
      wr_t_q <= '{default: 32'h00000000};
      rd_t_q <= '{default: 32'h00000000};
    end else begin
      cyc_q <= cyc_q + 32'h00000001;
      if (issue_q && issue_cmd_q == DCST_CMD_WR) begin
        wr_t_q[issue_rank_q] <= cyc_q;
      end
      if (issue_q && issue_cmd_q == DCST_CMD_RD) begin
        rd_t_q[issue_rank_q] <= cyc_q;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_wr;
    issue_q && issue_cmd_q == DCST_CMD_WR;
  endsequence
  sequence s_rd;
    issue_q && issue_cmd_q == DCST_CMD_RD;
  endsequence

  property p_one_pulse;
    issue_q |=> !issue_q;
  endproperty
  property p_from_req;
    issue_q |-> $past(req_valid) && issue_cmd_q == $past(req_cmd)
      && issue_rank_q == $past(req_rank) && issue_bank_q == $past(req_bank);
  endproperty
  property p_fields_hold;
    !issue_q |-> $stable(issue_cmd_q) && $stable(issue_rank_q) && $stable(issue_bank_q);
  endproperty
  property p_ww_same;
    s_wr |-> (cyc_q - wr_t_q[issue_rank_q]) >= {28'h0, wr_q[11:8]};
  endproperty
  property p_ww_other;
    s_wr |-> (cyc_q - wr_t_q[~issue_rank_q]) >= {28'h0, wr_q[7:4]};
  endproperty
  property p_rd_wr;
    s_wr |-> (cyc_q - rd_t_q[0]) >= {28'h0, wr_q[3:0]}
      && (cyc_q - rd_t_q[1]) >= {28'h0, wr_q[3:0]};
  endproperty
  property p_wr_rd_same;
    s_rd |-> (cyc_q - wr_t_q[issue_rank_q]) >= {27'h0, rd_q[16:12]};
  endproperty
  property p_wr_rd_other;
    s_rd |-> (cyc_q - wr_t_q[~issue_rank_q]) >= {28'h0, rd_q[11:8]};
  endproperty
  property p_rr_same;
    s_rd |-> (cyc_q - rd_t_q[issue_rank_q]) >= {28'h0, rd_q[7:4]};
  endproperty
  property p_rr_other;
    s_rd |-> (cyc_q - rd_t_q[~issue_rank_q]) >= {28'h0, rd_q[3:0]};
  endproperty

  a_one_pulse: assert property (p_one_pulse)
    else $error("launch pulse too long");
  a_from_req: assert property (p_from_req)
    else $error("launch differs from request");
  a_fields_hold: assert property (p_fields_hold)
    else $error("launch fields moved");
  a_ww_same: assert property (p_ww_same)
    else $error("write to write same rank too close");
  a_ww_other: assert property (p_ww_other)
    else $error("write to write other rank too close");
  a_rd_wr: assert property (p_rd_wr)
    else $error("read to write too close");
  a_wr_rd_same: assert property (p_wr_rd_same)
    else $error("write to read same rank too close");
  a_wr_rd_other: assert property (p_wr_rd_other)
    else $error("write to read other rank too close");
  a_rr_same: assert property (p_rr_same)
    else $error("read to read same rank too close");
  a_rr_other: assert property (p_rr_other)
    else $error("read to read other rank too close");
endmodule // dcst_tracker_chk

bind dcst_tracker dcst_tracker_chk chk_u (
  .clk_sys, .resetn, .reg_addr, .reg_wr, .reg_wdata, .req_valid, .req_cmd,
  .req_rank, .req_bank, .issue_q, .issue_cmd_q, .issue_rank_q, .issue_bank_q
);

// ==== verif/dcst_rank_model.sv ====
module dcst_rank_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // command bus from the tracker
  input  wire logic        issue_q,
  // launch record
  output logic [31:0]      seen_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // counts every cycle with issue_q high, so a held request launched twice shows up here
  always @(posedge clk_sys) begin
    if (!resetn) begin
      seen_cnt <= 32'h00000000;
    end else if (issue_q === 1'b1) begin
      seen_cnt <= seen_cnt + 32'h00000001;
    end
  end
endmodule // dcst_rank_model

// ==== verif/dcst_tracker_tb.sv ====
`include "dcst_params.svh"

module dcst_tracker_tb
  import dcst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata_q;
  logic        req_valid = 1'b0;
  dcst_cmd_t   req_cmd = DCST_CMD_ACT;
  dcst_rank_t  req_rank = 1'h0;
  dcst_bank_t  req_bank = 3'h0;
  logic        issue_q;
  dcst_cmd_t   issue_cmd_q;
  dcst_rank_t  issue_rank_q;
  dcst_bank_t  issue_bank_q;
  logic [31:0] seen_cnt;
  int          cyc = 0;
  int          launches = 0;
  int          fail_count = 0;
  int          num_checks = 0;

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  dcst_tracker dut_u (.clk_sys, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .req_valid, .req_cmd, .req_rank, .req_bank, .issue_q, .issue_cmd_q,
    .issue_rank_q, .issue_bank_q);
  dcst_rank_model rank_u (.clk_sys, .resetn, .issue_q, .seen_cnt);

  // ****
  // tasks
  // ****
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask

  // leaves the request up through the launch pulse; the next call replaces it at the edge that ends the pulse
  task automatic launch(input dcst_cmd_t c, input dcst_rank_t r, input dcst_bank_t b,
                        output int t);
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_rank <= r;
    req_bank <= b;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (issue_q !== 1'b1 && n < 600);
    if (n >= 600) begin
      fail_count++;
      $display("CHECK FAILED t=%0t no launch", $time);
      complete_run();
    end else begin
      launches++;
      t = cyc;
      chk(32'({issue_cmd_q, issue_rank_q, issue_bank_q}), 32'({c, r, b}));
    end
  endtask

  task automatic idle(input int n);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic gap(input dcst_cmd_t ca, input dcst_rank_t ra, input dcst_bank_t ba,
                     input dcst_cmd_t cb, input dcst_rank_t rb, input dcst_bank_t bb,
                     input int g);
    int ta;
    int tb;
    idle(40);
    launch(ca, ra, ba, ta);
    launch(cb, rb, bb, tb);
    chk(32'(tb - ta), 32'((g < 2) ? 2 : g));
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    int t [5];
    int i;
    logic [11:0] ofs [3];
    logic [31:0] msk [3];
    ofs = '{`DCST_OFS_ACT, `DCST_OFS_WR, `DCST_OFS_RD};
    msk = '{32'h0fffffff, 32'h0000ffff, 32'h001fffff};
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      reg_check(ofs[i], 32'h00000000);
      reg_write(ofs[i], 32'hffffffff);
      reg_check(ofs[i], msk[i]);
    end
    reg_write(12'h660, 32'hffffffff);
    reg_check(12'h660, 32'h00000000);
    $display("test registers done");
    reg_write(`DCST_OFS_ACT, 32'h000ad32c);
    reg_write(`DCST_OFS_WR, 32'h00003746);
    reg_write(`DCST_OFS_RD, 32'h001718a3);
    gap(DCST_CMD_ACT, 1'h0, 3'h0, DCST_CMD_ACT, 1'h0, 3'h1, 5);
    gap(DCST_CMD_PRE, 1'h0, 3'h2, DCST_CMD_ACT, 1'h0, 3'h2, 6);
    gap(DCST_CMD_PREALL, 1'h1, 3'h0, DCST_CMD_ACT, 1'h0, 3'h3, 9);
    gap(DCST_CMD_REF, 1'h1, 3'h0, DCST_CMD_ACT, 1'h1, 3'h0, 300);
    gap(DCST_CMD_ACT, 1'h0, 3'h4, DCST_CMD_WR, 1'h0, 3'h4, 3);
    gap(DCST_CMD_WR, 1'h0, 3'h4, DCST_CMD_WR, 1'h0, 3'h4, 7);
    gap(DCST_CMD_WR, 1'h0, 3'h4, DCST_CMD_WR, 1'h1, 3'h4, 4);
    gap(DCST_CMD_RD, 1'h0, 3'h0, DCST_CMD_WR, 1'h1, 3'h0, 6);
    gap(DCST_CMD_ACT, 1'h1, 3'h5, DCST_CMD_RD, 1'h1, 3'h5, 11);
    gap(DCST_CMD_WR, 1'h0, 3'h0, DCST_CMD_RD, 1'h0, 3'h0, 17);
    gap(DCST_CMD_WR, 1'h0, 3'h0, DCST_CMD_RD, 1'h1, 3'h0, 8);
    gap(DCST_CMD_RD, 1'h1, 3'h0, DCST_CMD_RD, 1'h1, 3'h0, 10);
    gap(DCST_CMD_RD, 1'h0, 3'h0, DCST_CMD_RD, 1'h1, 3'h0, 3);
    idle(40);
    launch(DCST_CMD_WR, 1'h0, 3'h1, t[0]);
    launch(DCST_CMD_WR, 1'h1, 3'h1, t[1]);
    launch(DCST_CMD_RD, 1'h0, 3'h1, t[2]);
    chk(32'(t[2] - t[0]), 32'h00000011);
    $display("test spacing done");
    idle(40);
    reg_write(`DCST_OFS_ACT, 32'h0a040000);
    for (i = 0; i < 5; i++) begin
      if (i == 4) reg_check(`DCST_OFS_STAT, 32'h00000044);
      launch(DCST_CMD_ACT, 1'h0, 3'(i), t[i]);
    end
    chk(32'(t[3] - t[0]), 32'h00000006);
    chk(32'(t[4] - t[0] >= 39 && t[4] - t[0] <= 42), 32'h00000001);
    $display("test window done");
    idle(60);
    reg_write(`DCST_OFS_ACT, 32'h0a240000);
    for (i = 0; i < 5; i++) launch(DCST_CMD_ACT, 1'h1, 3'(i), t[i]);
    chk(32'(t[4] - t[0]), 32'h00000008);
    idle(4);
    chk(seen_cnt, 32'(launches));
    $display("test limit off done");
    complete_run();
  end
endmodule // dcst_tracker_tb
